// [ctw_consts.svh]
`ifndef CTW_CONSTS_SVH
`define CTW_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define CTW_ADDR_CTRL 8'h00
`define CTW_ADDR_CLIENT_RATE 8'h04
`define CTW_ADDR_STATUS 8'h08
`define CTW_ADDR_TRUNK_RATE 8'h0C
`define CTW_ADDR_PM_WORDS 8'h10
`define CTW_ADDR_PM_ERRORS 8'h14

// ****************************************
// Fields and reset values
// ****************************************
`define CTW_CTRL_RESET 32'h00000000
`define CTW_CTRL_CLIENT_IS_BIT 0
`define CTW_CTRL_TRUNK_IS_BIT 1
`define CTW_CTRL_WRAP_BIT 2
`define CTW_CTRL_TYPE_LSB 4
`define CTW_CTRL_TYPE_MSB 7
`define CTW_RATE_RESET 32'h0025F6C0

// ****************************************
// Rates in kbit/s and wrapper constants
// ****************************************
`define CTW_PASS_MIN_KBPS 32'h00030D40
`define CTW_PASS_MAX_KBPS 32'h002450E0
`define CTW_RATIO_NUM 40'h00000000FF
`define CTW_RATIO_DEN 40'h00000000EE
`define CTW_FRAME_MARK 16'hF628
`define CTW_RESP_OKAY 2'h0
`define CTW_RESP_SLVERR 2'h2

`endif

// [ctw_pkg.sv]
package ctw_pkg;

    typedef enum logic [3:0] {
        CT_OC48, CT_FC2G, CT_GE, CT_FC1G, CT_OC12, CT_OC3, CT_VIDEO, CT_DATA
    } ctw_client_type;

    typedef struct packed {
        logic [3:0] client_type;
        logic wrap_request;
        logic trunk_in_service;
        logic client_in_service;
    } ctw_ctrl_type;

    typedef struct packed {
        logic [4:0] fifo_level;
        logic trunk_indicator;
        logic client_indicator;
        logic trunk_optics_ok;
        logic client_optics_ok;
        logic rate_ok;
        logic wrap_refused;
        logic rx_monitoring;
        logic tx_monitoring;
        logic standard_wrap;
        logic wrap_active;
        logic full_regeneration_mode;
    } ctw_status_type;

endpackage

// [ctw_top.sv]
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
`include "ctw_consts.svh"

// Overview of operation
// [R1] Client indicator: in service and signal detected
// [R2] Trunk indicator: in service and signal detected
// [R3] Both trunk outputs carry the processed client
// [R4] Wrapper surrounds payload, payload left unchanged
// [R5] Only OC-48 wrap is standard; rate follows client
// [R6] Wrapper and FEC off for pass-through types
// [R7] Wrapped trunk rate is client rate times 255/238
// [R8] Pass-through forwards client data, 200M to 2.38G
// [R9] Pass-through: no monitoring, only optics status
// [R10] Pass-through forwards trunk data to client unchanged
// [R11] Full regeneration wraps SONET, FC1G, FC2G, GE
// [R12] Monitoring for wrapped types except 2G Fibre Channel
// [R13] Wrapper rate scales with client frequency
// [R14] Trunk to client strips the wrapper
// [R15] Monitor wrapper overhead and SONET overhead on receive; only the wrapper header mark and trailer parity are checked
// [R16] Mode chosen from client type and rate
// [R17] Wrap request refused for pass-through types

// ****************************************
// Word FIFO
// ****************************************
module ctw_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic push;
    logic pop;

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
        $error("ctw_fifo: DEPTH must be a power of two");
    end

    assign in_ready = (level != (AW + 1)'(DEPTH));
    assign out_valid = (level != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            level <= level + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule

// ****************************************
// Client and trunk wrapper
// ****************************************
module ctw_top import ctw_pkg::*; #(
    parameter int FRAME_WORDS = 238,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Optics status pins
    input wire logic client_signal_detect,
    input wire logic trunk_signal_detect,
    // Client receive stream
    input wire logic [31:0] client_rx_data,
    input wire logic client_rx_valid,
    output logic client_rx_ready,
    // Trunk transmit streams, A and B
    output logic [31:0] trunk_a_tx_data,
    output logic [31:0] trunk_b_tx_data,
    output logic trunk_tx_valid,
    input wire logic trunk_a_tx_ready,
    input wire logic trunk_b_tx_ready,
    // Trunk receive stream
    input wire logic [31:0] trunk_rx_data,
    input wire logic trunk_rx_valid,
    output logic trunk_rx_ready,
    // Client transmit stream
    output logic [31:0] client_tx_data,
    output logic client_tx_valid,
    input wire logic client_tx_ready,
    // Port indicators
    output logic client_port_indicator,
    output logic trunk_port_indicator
);
    localparam int FW = 16;
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    // Status level field holds 16 at most
    if (FRAME_WORDS < 1 || FRAME_WORDS > 65534 || FIFO_DEPTH > 16) begin
        $error("ctw_top: FRAME_WORDS or FIFO_DEPTH out of range");
    end

    function automatic logic is_full_regen(input logic [3:0] t);
        return t <= 4'(CT_OC3);
    endfunction

    typedef enum logic [1:0] {TX_HEAD, TX_BODY, TX_TAIL} ctw_tx_state_type;

    ctw_ctrl_type ctrl;
    ctw_status_type status;
    logic [31:0] client_rate;
    logic [31:0] trunk_rate;
    logic [39:0] scaled_rate;
    logic [1:0] client_sync;
    logic [1:0] trunk_sync;
    logic full_regen;
    logic wrap_active;
    logic rate_ok;
    logic link_on;
    logic tx_pm;
    logic rx_pm;
    logic [31:0] pm_words;
    logic [15:0] oh_errors;
    logic [15:0] parity_errors;

    // ****************************************
    // Mode selection
    // ****************************************
    assign full_regen = is_full_regen(ctrl.client_type); // [R16] [R11]
    assign wrap_active = full_regen && ctrl.wrap_request; // [R6] [R17]
    assign rate_ok = client_rate >= `CTW_PASS_MIN_KBPS && client_rate <= `CTW_PASS_MAX_KBPS;
    assign link_on = full_regen || rate_ok; // [R8] [R10]
    assign tx_pm = full_regen && ctrl.client_type != 4'(CT_FC2G); // [R12] [R9]
    assign rx_pm = wrap_active && tx_pm; // [R15] [R9] [R12]
    assign scaled_rate = {8'h00, client_rate} * `CTW_RATIO_NUM / `CTW_RATIO_DEN;
    assign trunk_rate = wrap_active ? scaled_rate[31:0] : client_rate; // [R7] [R13] [R5]

    // ****************************************
    // Optics pins and indicators
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            client_sync <= 2'h0;
            trunk_sync <= 2'h0;
        end else begin
            client_sync <= {client_sync[0], client_signal_detect};
            trunk_sync <= {trunk_sync[0], trunk_signal_detect};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            client_port_indicator <= 1'b0;
            trunk_port_indicator <= 1'b0;
        end else begin
            client_port_indicator <= ctrl.client_in_service && client_sync[1]; // [R1]
            trunk_port_indicator <= ctrl.trunk_in_service && trunk_sync[1]; // [R2]
        end
    end

    // ****************************************
    // Client to trunk
    // ****************************************
    logic [31:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic [LW-1:0] fifo_level;
    logic out_free;
    logic [FW-1:0] tx_count;
    logic [31:0] tx_parity;
    ctw_tx_state_type tx_state;

    ctw_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) ctw_fifo_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_data(client_rx_data),
        .in_valid(client_rx_valid),
        .in_ready(client_rx_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .level(fifo_level)
    );

    assign out_free = !trunk_tx_valid || (trunk_a_tx_ready && trunk_b_tx_ready);
    assign fifo_pop = out_free && link_on && (!wrap_active || tx_state == TX_BODY);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_state <= TX_HEAD;
            tx_count <= '0;
            tx_parity <= 32'h00000000;
            trunk_tx_valid <= 1'b0;
            trunk_a_tx_data <= 32'h00000000;
            trunk_b_tx_data <= 32'h00000000;
        end else if (out_free) begin
            trunk_tx_valid <= 1'b0;
            if (!wrap_active) begin
                tx_state <= TX_HEAD;
                if (fifo_pop && fifo_valid) begin
                    trunk_tx_valid <= 1'b1; // [R8]
                    trunk_a_tx_data <= fifo_data;
                    trunk_b_tx_data <= fifo_data; // [R3]
                end
            end else begin
                case (tx_state)
                    TX_HEAD: begin
                        // Header waits for payload so its type is current
                        if (fifo_valid) begin
                            trunk_tx_valid <= 1'b1;
                            trunk_a_tx_data <= {`CTW_FRAME_MARK, 12'h000, ctrl.client_type}; // [R4]
                            trunk_b_tx_data <= {`CTW_FRAME_MARK, 12'h000, ctrl.client_type};
                            tx_parity <= 32'h00000000;
                            tx_count <= '0;
                            tx_state <= TX_BODY;
                        end
                    end
                    TX_BODY: begin
                        if (fifo_valid) begin
                            trunk_tx_valid <= 1'b1;
                            trunk_a_tx_data <= fifo_data; // [R4]
                            trunk_b_tx_data <= fifo_data; // [R3]
                            tx_parity <= tx_parity ^ fifo_data;
                            tx_count <= tx_count + 1'b1;
                            if (tx_count == FW'(FRAME_WORDS - 1)) begin
                                tx_state <= TX_TAIL;
                            end
                        end
                    end
                    TX_TAIL: begin
                        trunk_tx_valid <= 1'b1;
                        trunk_a_tx_data <= tx_parity;
                        trunk_b_tx_data <= tx_parity;
                        tx_state <= TX_HEAD;
                    end
                    default: begin
                        tx_state <= TX_HEAD;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pm_words <= 32'h00000000;
        end else if (tx_pm && fifo_pop && fifo_valid) begin
            pm_words <= pm_words + 32'h00000001; // [R12]
        end
    end

    // ****************************************
    // Trunk to client
    // ****************************************
    logic [FW-1:0] rx_pos;
    logic [31:0] rx_parity;
    logic rx_take;
    logic is_head;
    logic is_tail;

    assign trunk_rx_ready = link_on && (!client_tx_valid || client_tx_ready);
    assign rx_take = trunk_rx_valid && trunk_rx_ready;
    assign is_head = rx_pos == '0;
    assign is_tail = rx_pos == FW'(FRAME_WORDS + 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            client_tx_valid <= 1'b0;
            client_tx_data <= 32'h00000000;
        end else begin
            if (client_tx_ready) begin
                client_tx_valid <= 1'b0;
            end
            if (rx_take && (!wrap_active || !(is_head || is_tail))) begin
                client_tx_valid <= 1'b1; // [R14] [R10]
                client_tx_data <= trunk_rx_data;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_pos <= '0;
            rx_parity <= 32'h00000000;
            oh_errors <= 16'h0000;
            parity_errors <= 16'h0000;
        end else if (!wrap_active) begin
            rx_pos <= '0;
        end else if (rx_take) begin
            if (is_head) begin
                rx_parity <= 32'h00000000;
                if (trunk_rx_data[31:16] == `CTW_FRAME_MARK) begin
                    rx_pos <= FW'(1);
                end else if (rx_pm) begin
                    oh_errors <= oh_errors + 16'h0001; // [R15]
                end
            end else if (is_tail) begin
                rx_pos <= '0;
                if (rx_pm && trunk_rx_data != rx_parity) begin
                    parity_errors <= parity_errors + 16'h0001; // [R15]
                end
            end else begin
                rx_parity <= rx_parity ^ trunk_rx_data;
                rx_pos <= rx_pos + 1'b1;
            end
        end
    end

    // ****************************************
    // Status
    // ****************************************
    always_comb begin
        status.full_regeneration_mode = full_regen;
        status.wrap_active = wrap_active;
        status.standard_wrap = wrap_active && ctrl.client_type == 4'(CT_OC48); // [R5]
        status.tx_monitoring = tx_pm;
        status.rx_monitoring = rx_pm;
        status.wrap_refused = ctrl.wrap_request && !full_regen; // [R17]
        status.rate_ok = rate_ok;
        status.client_optics_ok = client_sync[1]; // [R9]
        status.trunk_optics_ok = trunk_sync[1];
        status.client_indicator = client_port_indicator;
        status.trunk_indicator = trunk_port_indicator;
        status.fifo_level = 5'(fifo_level);
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] ctrl_word;
    logic [31:0] next_ctrl;
    logic [31:0] next_rate;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign ctrl_word = 32'({ctrl.client_type, 1'b0, ctrl.wrap_request,
                            ctrl.trunk_in_service, ctrl.client_in_service});

    always_comb begin
        next_ctrl = ctrl_word;
        next_rate = client_rate;
        for (int i = 0; i < 4; i++) begin
            if (w_strb[i]) begin
                next_ctrl[i*8 +: 8] = w_data[i*8 +: 8];
                next_rate[i*8 +: 8] = w_data[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CTW_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_held && w_held) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == `CTW_ADDR_CTRL || aw_addr == `CTW_ADDR_CLIENT_RATE) ?
                               `CTW_RESP_OKAY : `CTW_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= ctw_ctrl_type'(`CTW_CTRL_RESET);
            client_rate <= `CTW_RATE_RESET;
        end else if (aw_held && w_held) begin
            if (aw_addr == `CTW_ADDR_CTRL) begin
                ctrl.client_in_service <= next_ctrl[`CTW_CTRL_CLIENT_IS_BIT];
                ctrl.trunk_in_service <= next_ctrl[`CTW_CTRL_TRUNK_IS_BIT];
                ctrl.wrap_request <= next_ctrl[`CTW_CTRL_WRAP_BIT];
                ctrl.client_type <= next_ctrl[`CTW_CTRL_TYPE_MSB:`CTW_CTRL_TYPE_LSB]; // [R16]
            end
            if (aw_addr == `CTW_ADDR_CLIENT_RATE) begin
                client_rate <= next_rate;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CTW_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `CTW_RESP_OKAY;
            case (s_axi_araddr)
                `CTW_ADDR_CTRL: s_axi_rdata <= ctrl_word;
                `CTW_ADDR_CLIENT_RATE: s_axi_rdata <= client_rate;
                `CTW_ADDR_STATUS: s_axi_rdata <= 32'(status);
                `CTW_ADDR_TRUNK_RATE: s_axi_rdata <= trunk_rate;
                `CTW_ADDR_PM_WORDS: s_axi_rdata <= pm_words;
                `CTW_ADDR_PM_ERRORS: s_axi_rdata <= {oh_errors, parity_errors};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `CTW_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    client_port_indicator_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
        client_port_indicator == $past(ctrl.client_in_service && client_sync[1]))
        else $error("client indicator wrong");
    trunk_led_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
        trunk_port_indicator |-> $past(ctrl.trunk_in_service && trunk_sync[1]))
        else $error("trunk indicator wrong");
    dual_trunk_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
        trunk_tx_valid |-> trunk_a_tx_data == trunk_b_tx_data)
        else $error("trunk copies differ");
    pass_data_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
        (!wrap_active && link_on && out_free && fifo_valid) ##1 !wrap_active
        |-> trunk_tx_valid && trunk_a_tx_data == $past(fifo_data))
        else $error("pass-through data altered");
    wrap_head_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
        (wrap_active && out_free && fifo_valid && tx_state == TX_HEAD) ##1 wrap_active
        |-> trunk_tx_valid && trunk_a_tx_data[31:16] == `CTW_FRAME_MARK)
        else $error("frame header missing");
    wrap_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R17]
        !full_regen |-> !wrap_active && !rx_pm && !tx_pm)
        else $error("wrapper on for pass-through type");
    rate_scale_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
        wrap_active |-> 40'(trunk_rate) * `CTW_RATIO_DEN <= {8'h00, client_rate} * `CTW_RATIO_NUM)
        else $error("trunk rate not scaled");
    fc2g_pm_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
        ctrl.client_type == 4'(CT_FC2G) |=> $stable(pm_words))
        else $error("monitoring on 2G fibre channel");
    strip_head_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
        (wrap_active && rx_take && is_head && !client_tx_valid) |=> !client_tx_valid)
        else $error("wrapper header reached client");
endmodule

// [ctw_line_model.sv]
`timescale 1ns/1ns
// ****
// Far-end line terminal, loops trunk back
// ****
module ctw_line_model (
    // Clock, reset, stall
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic stall,
    // Trunk streams
    input wire logic [31:0] trunk_a_tx_data,
    input wire logic [31:0] trunk_b_tx_data,
    input wire logic trunk_tx_valid,
    output logic trunk_a_tx_ready,
    output logic [31:0] trunk_rx_data,
    output logic trunk_rx_valid,
    input wire logic trunk_rx_ready,
    output logic copy_mismatch
);
    logic hold;
    assign hold = trunk_rx_valid && !trunk_rx_ready;
    assign trunk_a_tx_ready = !trunk_rx_valid && !stall;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trunk_rx_valid <= 1'h0;
            trunk_rx_data <= 32'h0;
            copy_mismatch <= 1'h0;
        end else if (trunk_tx_valid && trunk_a_tx_ready) begin
            trunk_rx_valid <= 1'h1;
            trunk_rx_data <= trunk_a_tx_data;
            copy_mismatch <= copy_mismatch || (trunk_a_tx_data !== trunk_b_tx_data);
        end else begin
            // Released data toggles
            trunk_rx_valid <= hold;
            trunk_rx_data <= hold ? trunk_rx_data : ~trunk_rx_data;
        end
    end
endmodule

// [ctw_top_tb_top.sv]
`timescale 1ns/1ns
`include "ctw_consts.svh"
// ****
// Stream and register bench
// ****
module ctw_top_tb_top;
    localparam logic [31:0] all_bits = 32'hFFFFFFFF;
    logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, client_rx_valid = 1'h0, client_tx_ready = 1'h1;
    logic stall = 1'h0, client_signal_detect = 1'h0, trunk_signal_detect = 1'h0, trunk_rx_valid;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, client_rx_ready;
    logic trunk_tx_valid, trunk_a_tx_ready, trunk_b_tx_ready, client_tx_valid, copy_mismatch;
    logic client_port_indicator, trunk_port_indicator, trunk_rx_ready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, client_rx_data = 32'h0, s_axi_rdata, trunk_a_tx_data, trunk_b_tx_data;
    logic [31:0] trunk_rx_data, client_tx_data, sent[$], got[$], line[$];
    logic [31:0] rates[6] = '{32'h0025F6C0, 32'h00206CC8, 32'h001312D0, 32'h00103664, 32'h00097E00, 32'h00025F80};
    logic [4:0] modes[6] = '{5'h1F, 5'h03, 5'h1B, 5'h1B, 5'h1B, 5'h1B};
    int err_count = 0, n_tests = 0;

    always #5 aclk = ~aclk;
    assign trunk_b_tx_ready = trunk_a_tx_ready;
    ctw_top #(.FRAME_WORDS(4)) ctw_top_i (.*);
    ctw_line_model ctw_line_model_i (.*);

    always @(posedge aclk) begin
        if (trunk_tx_valid && trunk_a_tx_ready && trunk_b_tx_ready) line.push_back(trunk_a_tx_data);
        if (client_tx_valid && client_tx_ready) got.push_back(client_tx_data);
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        err_count += (seen !== exp);
        if (seen !== exp) $display("ERROR %s expected %h seen %h", what, exp, seen);
    endtask

    task automatic wrap_up();
        if (err_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp = `CTW_RESP_OKAY);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, resp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp,
            input logic [1:0] resp = `CTW_RESP_OKAY);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        check("rresp", {30'h0, s_axi_rresp}, {30'h0, resp});
        check($sformatf("reg %h", a), s_axi_rdata & mask, exp);
    endtask

    task automatic send(input int n, input logic [31:0] base);
        for (int i = 0; i < n; i++) begin
            client_rx_data <= base + i;
            client_rx_valid <= 1'h1;
            sent.push_back(base + i);
            do @(posedge aclk); while (!client_rx_ready);
        end
        client_rx_valid <= 1'h0;
    endtask

    // Off is 1 when a header and trailer frame the payload
    task automatic drain(input int n, input int off, input logic [31:0] hdr);
        for (int k = 0; k < 400 && (got.size() < n || line.size() < n + 2 * off); k++) @(posedge aclk);
        check("count", 32'(got.size()), 32'(n));
        foreach (sent[i]) begin
            check("client word", got[i], sent[i]);
            check("trunk word", line[i + off], sent[i]);
        end
        if (off > 0) check("header", line[0], hdr);
        if (off > 0) check("trailer", line[n + 1], sent.xor());
        sent.delete();
        got.delete();
        line.delete();
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(`CTW_ADDR_CTRL, all_bits, `CTW_CTRL_RESET);
        rd(`CTW_ADDR_CLIENT_RATE, all_bits, `CTW_RATE_RESET);
        rd(8'h20, all_bits, 32'h0, `CTW_RESP_SLVERR);
        wr(`CTW_ADDR_STATUS, 32'h0, `CTW_RESP_SLVERR);
        client_signal_detect <= 1'h1;
        trunk_signal_detect <= 1'h1;
        wr(`CTW_ADDR_CLIENT_RATE, `CTW_PASS_MAX_KBPS);
        wr(`CTW_ADDR_CTRL, 32'h75);
        repeat (4) @(posedge aclk);
        rd(`CTW_ADDR_STATUS, 32'h7FF, 32'h3E0);
        wr(`CTW_ADDR_CTRL, 32'h76);
        repeat (4) @(posedge aclk);
        rd(`CTW_ADDR_STATUS, 32'h7FF, 32'h5E0);
        check("indicators", {30'h0, trunk_port_indicator, client_port_indicator}, 32'h2);
        rd(`CTW_ADDR_TRUNK_RATE, all_bits, `CTW_PASS_MAX_KBPS);
        send(6, 32'hA5000000);
        drain(6, 0, 32'h0);
        // Link off below minimum rate, far end stalled
        stall <= 1'h1;
        wr(`CTW_ADDR_CLIENT_RATE, `CTW_PASS_MIN_KBPS - 32'h1);
        fork
            send(20, 32'h5A000000);
        join_none
        repeat (40) @(posedge aclk);
        check("client ready", {31'h0, client_rx_ready}, 32'h0);
        rd(`CTW_ADDR_STATUS, 32'hF840, 32'h8000);
        wr(`CTW_ADDR_CLIENT_RATE, `CTW_PASS_MIN_KBPS);
        repeat (20) @(posedge aclk);
        stall <= 1'h0;
        wait fork;
        drain(20, 0, 32'h0);
        for (int t = 0; t < 6; t++) begin
            wr(`CTW_ADDR_CLIENT_RATE, rates[t]);
            wr(`CTW_ADDR_CTRL, {24'h0, t[3:0], 4'h7});
            rd(`CTW_ADDR_STATUS, 32'h1F, {27'h0, modes[t]});
            rd(`CTW_ADDR_TRUNK_RATE, all_bits, 32'((64'(rates[t]) * 64'hFF) / 64'hEE));
            send(4, {t[7:0], 24'h0});
            drain(4, 1, {`CTW_FRAME_MARK, 12'h0, t[3:0]});
        end
        rd(`CTW_ADDR_PM_ERRORS, all_bits, 32'h0);
        rd(`CTW_ADDR_PM_WORDS, all_bits, 32'h14);
        check("trunk copies", {31'h0, copy_mismatch}, 32'h0);
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        wrap_up();
    end
endmodule
